//--- pkg/pin_io_pkg.sv
// Constants for the multipurpose pin I/O and signal monitor block
// What this block does
// - Output-enable register, 8 bits read/write, index 44h, bit per pin.
// - Enable bit 7 makes the signal-input pin drive as general I/O.
// - Enable bit 6 stops clock output; pin driven from output register.
// - Enable bits 5 and 4 drive host-select pins 1 and 0 as I/O.
// - Enable bits 3..0 drive scan pins; ignored while boundary scan active.
// - Output value register at 45h, bits 7..0 drive the eight pins.
// - Read-only input level register at 46h, same bit order as outputs.
// - Control register 47h bit 7 picks fast switching; bits 6..4 reserved.
// - Monitor codes 0h,1h high impedance; 2h drives low; 3h drives high.
// - Codes 4h,5h,6h: transmit envelope, transmit active, secure channel.
// - Codes 7h,8h,9h: receive envelope, receive active, received bits.
// - Read-only ID register at 7Fh: version high nibble, subversion low.
package pin_io_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 7;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PIN_EN = 7'h44;
    localparam logic [IDX_W-1:0] IDX_PIN_OUT = 7'h45;
    localparam logic [IDX_W-1:0] IDX_PIN_IN = 7'h46;
    localparam logic [IDX_W-1:0] IDX_SIG_CTRL = 7'h47;
    localparam logic [IDX_W-1:0] IDX_REV_ID = 7'h7f;
    // Field positions
    localparam int BIT_SIGNAL_INPUT_PIN = 7;
    localparam int BIT_CLKPIN = 6;
    localparam int BIT_SEL1 = 5;
    localparam int BIT_SEL0 = 4;
    localparam int SCAN_MSB = 3;
    localparam int FAST_BIT = 7;
    localparam int SEL_MSB = 3;
    // Reset values
    localparam logic [7:0] RST_PIN_EN = 8'h00;
    localparam logic [7:0] RST_PIN_OUT = 8'h00;
    localparam logic [7:0] RST_SIG_CTRL = 8'h00;
    // Arbitrary identification values
    localparam logic [3:0] SILICON_VERSION = 4'h5;
    localparam logic [3:0] SILICON_SUBVERSION = 4'h3;
    // Monitor selector codes
    localparam logic [3:0] MON_HIZ0 = 4'h0;
    localparam logic [3:0] MON_HIZ1 = 4'h1;
    localparam logic [3:0] MON_LOW = 4'h2;
    localparam logic [3:0] MON_HIGH = 4'h3;
    localparam logic [3:0] MON_TX_ENV = 4'h4;
    localparam logic [3:0] MON_TX_ACT = 4'h5;
    localparam logic [3:0] MON_SECURE = 4'h6;
    localparam logic [3:0] MON_RX_ENV = 4'h7;
    localparam logic [3:0] MON_RX_ACT = 4'h8;
    localparam logic [3:0] MON_RX_BIT = 4'h9;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/pin_io_monitor.sv
// AXI4-Lite general purpose pin I/O with signal monitor output
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module pin_io_monitor
    import pin_io_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    input wire logic [7:0] dedicated_value,
    input wire logic [7:0] dedicated_enable,
    input wire logic boundary_scan_active,
    input wire logic tx_envelope,
    input wire logic tx_active,
    input wire logic secure_channel_signal,
    input wire logic rx_envelope,
    input wire logic rx_active,
    input wire logic rx_bit,
    output logic signal_output_pin_out,
    output logic signal_output_pin_oe_n,
    output logic fast_switch_select
);
    logic [7:0] pin_output_enables_r;
    logic [7:0] pin_output_value_r;
    logic [7:0] signal_output_control_r;
    logic [7:0] pin_input_level;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane0_r;
    logic aw_held_r;
    logic w_held_r;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    logic [3:0] monitor_source_select;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [IDX_W-1:0] idx);
        hit = (addr[ADDR_W-1:2] == {3'h0, idx});
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        mapped = hit(addr, IDX_PIN_EN) || hit(addr, IDX_PIN_OUT) ||
                 hit(addr, IDX_PIN_IN) || hit(addr, IDX_SIG_CTRL) ||
                 hit(addr, IDX_REV_ID);
    endfunction

    // Scan pins belong to the scan logic when it is enabled
    function automatic logic gpio_owns(input int unsigned i,
                                       input logic [7:0] en,
                                       input logic scan);
        gpio_owns = en[i] && !(i <= SCAN_MSB && scan);
    endfunction

    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign monitor_source_select = signal_output_control_r[SEL_MSB:0];

    pin_level_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pin_in),
        .sync_out(pin_input_level)
    );

    // Address and data are captured independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            s_axi_awready <= 1'b1;
        end else if (aw_hs) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_lane0_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (w_hs) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Writable registers; writes to read-only ones are dropped quietly
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_output_enables_r <= RST_PIN_EN;
            pin_output_value_r <= RST_PIN_OUT;
            signal_output_control_r <= RST_SIG_CTRL;
        end else if (wr_go && w_lane0_r) begin
            if (hit(aw_addr_r, IDX_PIN_EN)) begin
                pin_output_enables_r <= w_data_r;
            end
            if (hit(aw_addr_r, IDX_PIN_OUT)) begin
                pin_output_value_r <= w_data_r;
            end
            if (hit(aw_addr_r, IDX_SIG_CTRL)) begin
                // Reserved bits are kept at zero
                signal_output_control_r <= w_data_r & 8'h8f;
            end
        end
    end

    // Read path answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (hit(s_axi_araddr, IDX_PIN_EN)) begin
                s_axi_rdata <= {24'h00_0000, pin_output_enables_r};
            end else if (hit(s_axi_araddr, IDX_PIN_OUT)) begin
                s_axi_rdata <= {24'h00_0000, pin_output_value_r};
            end else if (hit(s_axi_araddr, IDX_PIN_IN)) begin
                s_axi_rdata <= {24'h00_0000, pin_input_level};
            end else if (hit(s_axi_araddr, IDX_SIG_CTRL)) begin
                s_axi_rdata <= {24'h00_0000, signal_output_control_r};
            end else if (hit(s_axi_araddr, IDX_REV_ID)) begin
                s_axi_rdata <= {24'h00_0000, SILICON_VERSION,
                                SILICON_SUBVERSION};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Pin drivers: register value when enabled, else dedicated function; scan pins keep the dedicated function during boundary scan
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 8'h00;
            pin_oe_n <= 8'hff;
        end else begin
            for (int unsigned i = 0; i < 8; i++) begin
                if (gpio_owns(i, pin_output_enables_r,
                              boundary_scan_active)) begin
                    pin_out[i] <= pin_output_value_r[i];
                    pin_oe_n[i] <= 1'b0;
                end else begin
                    pin_out[i] <= dedicated_value[i];
                    pin_oe_n[i] <= !dedicated_enable[i];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_switch_select <= 1'b0;
        end else begin
            // Pad speed follows the control bit
            fast_switch_select <= signal_output_control_r[FAST_BIT];
        end
    end

    // Monitor output; the routed strobes share this clock domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            signal_output_pin_out <= 1'b0;
            signal_output_pin_oe_n <= 1'b1;
        end else begin
            signal_output_pin_oe_n <= 1'b0;
            case (monitor_source_select)
                MON_LOW: signal_output_pin_out <= 1'b0;
                MON_HIGH: signal_output_pin_out <= 1'b1;
                MON_TX_ENV: signal_output_pin_out <= tx_envelope;
                MON_TX_ACT: signal_output_pin_out <= tx_active;
                MON_SECURE: signal_output_pin_out <= secure_channel_signal;
                // Receive envelope only meaningful at 106 kBd type A
                MON_RX_ENV: signal_output_pin_out <= rx_envelope;
                MON_RX_ACT: signal_output_pin_out <= rx_active;
                MON_RX_BIT: signal_output_pin_out <= rx_bit;
                default: begin
                    signal_output_pin_out <= 1'b0;
                    signal_output_pin_oe_n <= 1'b1;
                end
            endcase
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_to(logic [IDX_W-1:0] idx);
        wr_go && w_lane0_r && hit(aw_addr_r, idx);
    endsequence

    sequence s_read_of(logic [IDX_W-1:0] idx);
        ar_hs && hit(s_axi_araddr, idx);
    endsequence

    a_write_resp_timely: assert property (
        wr_go |=> s_axi_bvalid && !aw_held_r && !w_held_r)
        else $error("write response not raised after address and data");

    a_enable_reg_write: assert property (
        s_write_to(IDX_PIN_EN) |=>
            pin_output_enables_r == $past(w_data_r))
        else $error("output enable register did not take written data");

    a_signal_input_pin_gpio_drive: assert property (
        pin_output_enables_r[BIT_SIGNAL_INPUT_PIN] |=>
            !pin_oe_n[BIT_SIGNAL_INPUT_PIN] &&
            pin_out[BIT_SIGNAL_INPUT_PIN] == $past(pin_output_value_r[BIT_SIGNAL_INPUT_PIN]))
        else $error("signal input pin not driven from output register");

    a_clock_pin_gpio: assert property (
        pin_output_enables_r[BIT_CLKPIN] |=>
            !pin_oe_n[BIT_CLKPIN] &&
            pin_out[BIT_CLKPIN] == $past(pin_output_value_r[BIT_CLKPIN]))
        else $error("clock pin still carries clock function");

    a_select_pin_drive: assert property (
        pin_output_enables_r[BIT_SEL1] && pin_output_enables_r[BIT_SEL0]
        |=> pin_oe_n[BIT_SEL1:BIT_SEL0] == 2'b00)
        else $error("host select pins not driven when enabled");

    a_scan_ignores_en: assert property (
        boundary_scan_active |=>
            pin_oe_n[SCAN_MSB:0] == ~$past(dedicated_enable[SCAN_MSB:0]))
        else $error("scan pin enable acted during boundary scan");

    a_output_value_path: assert property (
        s_write_to(IDX_PIN_OUT) ##1 pin_output_enables_r[0] &&
            !boundary_scan_active |=> pin_out[0] == $past(w_data_r[0], 2))
        else $error("written output value did not reach the pin");

    a_input_level_read: assert property (
        s_read_of(IDX_PIN_IN) |=>
            s_axi_rvalid && s_axi_rdata[7:0] == $past(pin_input_level))
        else $error("input register read returned wrong level");

    a_reserved_read_zero: assert property (
        s_read_of(IDX_SIG_CTRL) |=> s_axi_rdata[6:4] == 3'h0 &&
            s_axi_rdata[7] == fast_switch_select)
        else $error("control register read shows reserved bits");

    a_monitor_hiz: assert property (
        (monitor_source_select <= MON_HIZ1 ||
         monitor_source_select > MON_RX_BIT) |=> signal_output_pin_oe_n)
        else $error("monitor pin driven for a high impedance code");

    a_monitor_constant: assert property (
        monitor_source_select == MON_HIGH |=>
            !signal_output_pin_oe_n && signal_output_pin_out)
        else $error("monitor pin not driven high for constant code");

    a_monitor_tx_route: assert property (
        monitor_source_select == MON_TX_ENV |=>
            signal_output_pin_out == $past(tx_envelope))
        else $error("transmit envelope not routed to monitor pin");

    a_monitor_rx_route: assert property (
        monitor_source_select == MON_RX_BIT |=>
            !signal_output_pin_oe_n && signal_output_pin_out == $past(rx_bit))
        else $error("received bits not routed to monitor pin");

    a_revision_read: assert property (
        s_read_of(IDX_REV_ID) |=>
            s_axi_rdata == {24'h00_0000, SILICON_VERSION, SILICON_SUBVERSION})
        else $error("identification register read wrong");

    a_dedicated_kept: assert property (
        !pin_output_enables_r[BIT_SEL1] |=>
            pin_oe_n[BIT_SEL1] == !$past(dedicated_enable[BIT_SEL1]))
        else $error("disabled pin not left to its dedicated function");
endmodule

//--- rtl/pin_level_sync.sv
// Two-flop synchroniser bank for the pin input levels
`timescale 1ns/1ns
module pin_level_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    logic [7:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 8'h00;
            sync_out <= 8'h00;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- verif/pin_partner.sv
// Board-side model of the circuitry on the eight multipurpose pins
`timescale 1ns/1ns
module pin_partner (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // Board drives through a resistor, so a driving pad wins
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
        end
    end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the pin I/O and signal monitor block
`timescale 1ns/1ns
module testbench;
    import pin_io_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] pin_in, pin_out, pin_oe_n;
    logic [7:0] ext_level = '0, dedicated_value = '0, dedicated_enable = '0;
    logic boundary_scan_active = 1'h0;
    logic [5:0] src = '0;
    logic signal_output_pin_out, signal_output_pin_oe_n, fast_switch_select;
    int n_mismatch = 0;
    int checks = 0;

    always #10 aclk = ~aclk;

    pin_io_monitor uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n,
        .dedicated_value, .dedicated_enable, .boundary_scan_active,
        .tx_envelope(src[0]), .tx_active(src[1]),
        .secure_channel_signal(src[2]), .rx_envelope(src[3]),
        .rx_active(src[4]), .rx_bit(src[5]), .signal_output_pin_out,
        .signal_output_pin_oe_n, .fast_switch_select
    );

    pin_partner board (.pin_out, .pin_oe_n, .ext_level, .pin_in);

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic timeout(string what);
        n_mismatch++;
        $display("ERROR %s expected answer seen timeout", what);
        finish_test();
    endtask

    task automatic chk_val(string what, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_resp(string what, logic [1:0] e, logic [1:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s response expected %h seen %h", what, e, g);
        end
    endtask

    // Ready stays high, so the answer is taken at the edge it shows
    task automatic axi_write(logic [11:0] a, logic [7:0] d, logic s,
                             output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= {3'h7, s};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        if (n == 50) timeout("write");
    endtask

    task automatic axi_read(logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 50) timeout("read");
    endtask

    task automatic wr(logic [IDX_W-1:0] i, logic [7:0] d);
        logic [1:0] r;
        axi_write({3'h0, i, 2'h0}, d, 1'h1, r);
        chk_resp("write", RESP_OKAY, r);
    endtask

    task automatic rd_chk(logic [IDX_W-1:0] i, logic [7:0] e, string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read({3'h0, i, 2'h0}, d, r);
        chk_resp(what, RESP_OKAY, r);
        chk_val(what, {24'h00_0000, e}, d);
    endtask

    // Returns drive enables (active low) above pad values
    function automatic logic [15:0] exp_pins(logic [7:0] en, logic [7:0] ov,
                                             logic [7:0] dv, logic [7:0] de,
                                             logic sc);
        logic [7:0] oe_n;
        logic [7:0] o;
        for (int i = 0; i < 8; i++) begin
            if (en[i] && !(i <= SCAN_MSB && sc)) begin
                oe_n[i] = 1'h0;
                o[i] = ov[i];
            end else begin
                oe_n[i] = !de[i];
                o[i] = dv[i];
            end
        end
        return {oe_n, o};
    endfunction

    function automatic logic [1:0] exp_mon(logic [3:0] c, logic [5:0] s);
        case (c)
            MON_LOW: return 2'h0;
            MON_HIGH: return 2'h1;
            MON_TX_ENV, MON_TX_ACT, MON_SECURE, MON_RX_ENV, MON_RX_ACT,
            MON_RX_BIT: return {1'h0, s[c - 4'h4]};
            default: return 2'h2;
        endcase
    endfunction

    initial begin
        logic [7:0] en, ov, lvl, m, id;
        logic [15:0] e;
        logic [31:0] d, mg;
        logic [1:0] r;
        logic fs;
        void'($urandom(91756));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        id = {SILICON_VERSION, SILICON_SUBVERSION};
        mg = 32'(signal_output_pin_oe_n);
        chk_val("pin_oe_n", 32'h0000_00ff, 32'(pin_oe_n));
        chk_val("monitor_oe_n", 32'h0000_0001, mg);
        rd_chk(IDX_PIN_EN, 8'h00, "enables");
        rd_chk(IDX_PIN_OUT, 8'h00, "output value");
        rd_chk(IDX_REV_ID, id, "id");
        $display("Test reset values done");

        ext_level <= 8'h3c;
        wr(IDX_PIN_IN, 8'ha5);
        wr(IDX_REV_ID, 8'h5a);
        axi_write({3'h0, IDX_PIN_EN, 2'h0}, 8'hff, 1'h0, r);
        chk_resp("masked write", RESP_OKAY, r);
        rd_chk(IDX_PIN_EN, 8'h00, "enables");
        rd_chk(IDX_REV_ID, id, "id");
        rd_chk(IDX_PIN_IN, 8'h3c, "input level");
        axi_write(12'h200, 8'hff, 1'h1, r);
        chk_resp("unmapped write", RESP_SLVERR, r);
        axi_read(12'h200, d, r);
        chk_resp("unmapped read", RESP_SLVERR, r);
        chk_val("unmapped read", 32'h0000_0000, d);
        $display("Test access kinds done");

        for (int k = 0; k < 24; k++) begin
            en = (k == 0) ? 8'hff : 8'($urandom);
            ov = 8'($urandom);
            dedicated_value <= 8'($urandom);
            dedicated_enable <= 8'($urandom);
            boundary_scan_active <= (k < 2) ? k[0] : 1'($urandom);
            ext_level <= 8'($urandom);
            wr(IDX_PIN_EN, en);
            wr(IDX_PIN_OUT, ov);
            repeat (5) @(posedge aclk);
            e = exp_pins(en, ov, dedicated_value, dedicated_enable,
                         boundary_scan_active);
            lvl = (~e[15:8] & e[7:0]) | (e[15:8] & ext_level);
            m = ~e[15:8];
            chk_val("oe signal_input_pin", 32'(e[15]), 32'(pin_oe_n[7]));
            chk_val("oe clock", 32'(e[14]), 32'(pin_oe_n[6]));
            chk_val("oe sel", 32'(e[13:12]), 32'(pin_oe_n[5:4]));
            chk_val("oe scan", 32'(e[11:8]), 32'(pin_oe_n[3:0]));
            chk_val("pin_oe_n", 32'(e[15:8]), 32'(pin_oe_n));
            chk_val("pin_out", 32'(e[7:0] & m), 32'(pin_out & m));
            rd_chk(IDX_PIN_EN, en, "enables");
            rd_chk(IDX_PIN_OUT, ov, "output value");
            rd_chk(IDX_PIN_IN, lvl, "input level");
        end
        $display("Test pin drive done");

        for (int c = 0; c < 16; c++) begin
            fs = 1'($urandom);
            wr(IDX_SIG_CTRL, {fs, 3'h7, 4'(c)});
            rd_chk(IDX_SIG_CTRL, {fs, 3'h0, 4'(c)}, "control");
            for (int j = 0; j < 2; j++) begin
                src <= (j == 0) ? 6'($urandom) : ~src;
                repeat (2) @(posedge aclk);
                chk_val("fast", 32'(fs), 32'(fast_switch_select));
                d = 32'(exp_mon(4'(c), src));
                mg = 32'({signal_output_pin_oe_n, signal_output_pin_out});
                chk_val("monitor", d, mg);
            end
        end
        $display("Test monitor select done");

        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd_chk(IDX_PIN_EN, 8'h00, "enables");
        rd_chk(IDX_SIG_CTRL, 8'h00, "control");
        $display("Test second reset done");
        finish_test();
    end
endmodule
